/* File: logic/ssa_pkg.sv */
// Purpose: Shared constants and types of the serial step attenuator control
// Assumes: 16-bit write frames shifted MSB first while the latch enable is low
// Notes:   Frame layout is chip address, one spare bit, register address, data
package ssa_pkg;

  // Frame geometry
  localparam int          FRAME_BITS  = 16;
  localparam int          CNT_W       = 5;
  localparam logic [4:0]  FRAME_CNT   = 5'h10;
  localparam logic [4:0]  CNT_SAT     = 5'h1f;
  localparam int          CHIP_MSB    = 15;
  localparam int          CHIP_LSB    = 13;
  localparam int          REG_MSB     = 11;
  localparam int          REG_LSB     = 8;
  localparam int          CODE_MSB    = 6;
  localparam int          CFG_MSB     = 7;

  // Register addresses
  localparam logic [3:0]  REG_PRIMARY   = 4'h0;
  localparam logic [3:0]  REG_CONFIG    = 4'h1;
  localparam logic [3:0]  REG_ALTERNATE = 4'h2;

  // Attenuation code and reset values
  localparam int          CODE_W        = 7;
  localparam logic [6:0]  CODE_MAX      = 7'h7f;
  localparam logic [6:0]  CODE_MIN      = 7'h00;
  localparam logic [6:0]  PRIMARY_RST   = 7'h7f;
  localparam logic [6:0]  ALTERNATE_RST = 7'h7f;
  localparam logic [7:0]  CONFIG_RST    = 8'h00;

  // Configuration fields
  localparam int          CFG_POINTER_BIT = 0;
  localparam int          CFG_ENABLE_BIT  = 1;

  // Chip address that the internal pulls give to open pins
  localparam logic [2:0]  CHIP_ID_DEFAULT = 3'h6;

  // Synchroniser reset levels
  localparam logic [5:0]  SYNC_RST    = 6'h00;
  localparam logic [0:0]  LATCH_IDLE  = 1'h1;

  // Frame receiver states
  typedef enum logic [0:0]
  {
    FRM_IDLE,
    FRM_SHIFT
  } ssa_frm_state_t;

endpackage

/* File: logic/ssa_sync.sv */
// Purpose: Two-flop synchroniser for pins that arrive from outside core_clk
// Assumes: Each bit is an independent level; no bus coherence is promised
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module ssa_sync
#(
  parameter int                 WIDTH   = 1,
  parameter logic [WIDTH-1:0]   RST_VAL = '0
)
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // Levels
  input  wire logic [WIDTH-1:0]   asyncIn,
  output logic      [WIDTH-1:0]   syncOut
);

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1_r <= RST_VAL;
      syncOut  <= RST_VAL;
    end
    else
    begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end

endmodule // ssa_sync

/* File: logic/ssa_control.sv */
// Purpose: Serial write port, register file and core drive of a step attenuator
// Assumes: Serial clock far slower than core_clk; frames end on latch enable rise
// Notes:   Core cell enables and status outputs all come straight from flip-flops
`timescale 1ns/1ps

// Function
// RL1: Each register write is one 16-bit frame carrying a three-bit chip address.
// RL2: Act on a frame only when its chip address equals the chip-ID pins.
// RL3: Unconnected chip-ID pins resolve to 110, chip address six.
// RL4: Register address 0 primary, 1 configuration, 2 alternate attenuation.
// RL5: Attenuation is a 7-bit code of 0.25 dB steps; 127 is 31.75 dB.
// RL6: Code zero bypasses every attenuation cell.
// RL7: With alternate off, a primary write applies as soon as the frame ends.
// RL8: Alternate enabled and select pin high drive the core from register 2.
// RL9: Select pin low drives the core from the primary register.
// RL10: Select pin does nothing until the alternate feature is enabled.
// RL11: Host enables the feature by writing three to the configuration register.
// RL12: Reset loads the alternate register with the 31.75 dB code.
// RL13: Configuration bit 1 enables the feature; bit 0 points at register 2.
// RL14: Reset loads the primary register with 01111111, maximum attenuation.
// RL15: Code bits 6 to 0 drive the 16 down to 0.25 dB cells.
// RL16: Reset clears every configuration bit, disabling the alternate feature.
// RL17: Data bit 7 of both attenuation registers is ignored.
module ssa_control
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // Serial write port
  input  wire logic         serClk,
  input  wire logic         serData,
  input  wire logic         latchEn,
  // Static select
  input  wire logic         alternateSelectPin,
  // Chip identity pins and their open-pin flags
  input  wire logic         chipIdPin0,
  input  wire logic         chipIdPin1,
  input  wire logic         chipIdPin2,
  input  wire logic [2:0]   chipIdOpen,
  // Attenuator core drive
  output logic [6:0]        coreCellEn_r,
  // Status
  output logic              altActive_r,
  output logic              frameAck_r
);

  // Synchronised pins
  logic [5:0]                   pinSync;
  logic [0:0]                   latchSync;
  logic [2:0]                   openSync;
  logic                         sclkS;
  logic                         sdataS;
  logic                         altSelS;
  logic [2:0]                   idPinS;
  logic                         latchS;

  // Frame receiver
  ssa_pkg::ssa_frm_state_t      frmState_r;
  ssa_pkg::ssa_frm_state_t      frmState_nxt;
  logic                         sclkOld_r;
  logic                         latchOld_r;
  logic                         sclkRise;
  logic                         latchRise;
  logic                         latchFall;
  logic [15:0]                  shift_r;
  logic [4:0]                   bitCnt_r;
  logic                         frameEnd;

  // Decode
  logic [2:0]                   chipId_r;
  logic [2:0]                   frmChip;
  logic [3:0]                   frmReg;
  logic [7:0]                   frmData;
  logic                         frameOk;

  // Registers
  logic [6:0]                   primary_r;
  logic [7:0]                   config_r;
  logic [6:0]                   alternate_r;
  logic                         useAlt;

  ssa_sync
  #(
    .WIDTH   (6),
    .RST_VAL (ssa_pkg::SYNC_RST)
  )
  u_pinSync
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  ({serClk, serData, alternateSelectPin, chipIdPin2, chipIdPin1, chipIdPin0}),
    .syncOut  (pinSync)
  );

  // Latch enable idles high, so its chain resets high to avoid a false frame end
  ssa_sync
  #(
    .WIDTH   (1),
    .RST_VAL (ssa_pkg::LATCH_IDLE)
  )
  u_latchSync
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (latchEn),
    .syncOut  (latchSync)
  );

  ssa_sync
  #(
    .WIDTH   (3),
    .RST_VAL (ssa_pkg::SYNC_RST[2:0])
  )
  u_openSync
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (chipIdOpen),
    .syncOut  (openSync)
  );

  assign sclkS   = pinSync[5];
  assign sdataS  = pinSync[4];
  assign altSelS = pinSync[3];
  assign idPinS  = pinSync[2:0];
  assign latchS  = latchSync[0];

  // Edge detection on the synchronised copies only
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclkOld_r  <= 1'b0;
      latchOld_r <= 1'b1;
    end
    else
    begin
      sclkOld_r  <= sclkS;
      latchOld_r <= latchS;
    end
  end

  assign sclkRise  = sclkS & ~sclkOld_r;
  assign latchRise = latchS & ~latchOld_r;
  assign latchFall = ~latchS & latchOld_r;

  // Open pins take the pull pattern
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      chipId_r <= ssa_pkg::CHIP_ID_DEFAULT;
    else
      chipId_r <= (openSync & ssa_pkg::CHIP_ID_DEFAULT) | (~openSync & idPinS); // see RL3
  end

  always_comb
  begin
    frmState_nxt = frmState_r;
    case (frmState_r)
      ssa_pkg::FRM_IDLE:
        if (latchFall)
          frmState_nxt = ssa_pkg::FRM_SHIFT;
      ssa_pkg::FRM_SHIFT:
        if (latchRise)
          frmState_nxt = ssa_pkg::FRM_IDLE;
      default:
        frmState_nxt = ssa_pkg::FRM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      frmState_r <= ssa_pkg::FRM_IDLE;
    else
      frmState_r <= frmState_nxt;
  end

  // Shift MSB first; count saturates so overlong frames never wrap to 16
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift_r  <= '0;
      bitCnt_r <= '0;
    end
    else if (frmState_r == ssa_pkg::FRM_IDLE)
    begin
      if (latchFall)
        bitCnt_r <= '0;
    end
    else if (sclkRise && !latchRise)
    begin
      shift_r <= {shift_r[ssa_pkg::FRAME_BITS-2:0], sdataS};
      if (bitCnt_r != ssa_pkg::CNT_SAT)
        bitCnt_r <= bitCnt_r + 5'h01;
    end
  end

  assign frameEnd = (frmState_r == ssa_pkg::FRM_SHIFT) && latchRise;
  assign frmChip  = shift_r[ssa_pkg::CHIP_MSB:ssa_pkg::CHIP_LSB];
  assign frmReg   = shift_r[ssa_pkg::REG_MSB:ssa_pkg::REG_LSB];
  assign frmData  = shift_r[ssa_pkg::CFG_MSB:0];
  assign frameOk  = frameEnd && (bitCnt_r == ssa_pkg::FRAME_CNT) // see RL1
                 && (frmChip == chipId_r);                       // see RL2

  // Bit 7 is never stored in the attenuation words
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      primary_r <= ssa_pkg::PRIMARY_RST; // see RL14
    else if (frameOk && frmReg == ssa_pkg::REG_PRIMARY) // see RL4
      primary_r <= frmData[ssa_pkg::CODE_MSB:0]; // see RL17 see RL5 see RL7
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      config_r <= ssa_pkg::CONFIG_RST; // see RL16
    else if (frameOk && frmReg == ssa_pkg::REG_CONFIG)
      config_r <= frmData;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      alternate_r <= ssa_pkg::ALTERNATE_RST; // see RL12
    else if (frameOk && frmReg == ssa_pkg::REG_ALTERNATE)
      alternate_r <= frmData[ssa_pkg::CODE_MSB:0]; // see RL17
  end

  // Feature on plus pointer set routes the select pin; otherwise primary wins
  assign useAlt = config_r[ssa_pkg::CFG_ENABLE_BIT]    // see RL10
               && config_r[ssa_pkg::CFG_POINTER_BIT]   // see RL13
               && altSelS;

  // Code bits map one to one onto cells, so code zero bypasses all of them
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      coreCellEn_r <= ssa_pkg::PRIMARY_RST;
      altActive_r  <= 1'b0;
    end
    else
    begin
      coreCellEn_r <= useAlt ? alternate_r : primary_r; // see RL8 see RL9 see RL15 see RL6
      altActive_r  <= useAlt;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      frameAck_r <= 1'b0;
    else
      frameAck_r <= frameOk;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence primWrite_s;
    frameOk && frmReg == ssa_pkg::REG_PRIMARY && !config_r[ssa_pkg::CFG_ENABLE_BIT];
  endsequence

  sequence holdPrimary_s;
    !frameOk [*2];
  endsequence

  chip_mismatch_a: assert property (frameEnd && frmChip != chipId_r |=> // see RL2
    $stable(primary_r) && $stable(config_r) && $stable(alternate_r))
    else $error("Frame for another chip changed a register");

  frame_length_a: assert property (frameEnd && bitCnt_r != ssa_pkg::FRAME_CNT |=> // see RL1
    !frameAck_r)
    else $error("Frame of wrong length was accepted");

  // Accepting cycle, then two quiet ones; the core must show the word by then
  prim_apply_a: assert property (primWrite_s ##1 holdPrimary_s |-> // see RL7
    coreCellEn_r == primary_r)
    else $error("Primary write not applied two cycles after frame end");

  alt_write_a: assert property (frameOk && frmReg == ssa_pkg::REG_ALTERNATE |=> // see RL4
    alternate_r == $past(frmData[ssa_pkg::CODE_MSB:0]))
    else $error("Alternate register not loaded from frame");

  cfg_write_a: assert property (frameOk && frmReg == ssa_pkg::REG_CONFIG |=> // see RL13
    config_r == $past(frmData))
    else $error("Configuration register not loaded from frame");

  // Word before the edge; a write on that same edge reaches the core a cycle later
  alt_drive_a: assert property (useAlt |=> altActive_r && // see RL8
    coreCellEn_r == $past(alternate_r))
    else $error("Core not driven from alternate register");

  sel_low_a: assert property (!altSelS |=> !altActive_r && // see RL9
    coreCellEn_r == $past(primary_r))
    else $error("Core not driven from primary with select low");

  sel_ignored_a: assert property (!config_r[ssa_pkg::CFG_ENABLE_BIT] |=> // see RL10
    !altActive_r)
    else $error("Select pin acted with feature disabled");

  reset_values_a: assert property ($past(sys_rst) |-> // see RL12 see RL14 see RL16
    primary_r == ssa_pkg::CODE_MAX && alternate_r == ssa_pkg::CODE_MAX
    && config_r == ssa_pkg::CONFIG_RST)
    else $error("Register reset value wrong");

  bit7_ignored_a: assert property (frameOk && frmReg == ssa_pkg::REG_PRIMARY |=> // see RL17
    primary_r[ssa_pkg::CODE_MSB:0] == $past(shift_r[ssa_pkg::CODE_MSB:0]))
    else $error("Primary word not the low seven data bits");

  default_id_a: assert property (&openSync |=> // see RL3
    chipId_r == ssa_pkg::CHIP_ID_DEFAULT)
    else $error("Open chip-ID pins did not give the default address");

  ack_pulse_a: assert property (frameAck_r |=> !frameAck_r) // see RL1
    else $error("Frame acknowledge longer than one cycle");

endmodule // ssa_control

/* File: tb/ssa_host_model.sv */
// Purpose: Host side of the serial write port and the static select pin
// Assumes: Serial clock idles low and runs only inside a frame
// Notes:   Data line shows the inverse of its last bit once hold time is over
`timescale 1ns/1ps
module ssa_host_model
(
  // Serial write port
  output logic serClk,
  output logic serData,
  output logic latchEn,
  // Static select
  output logic alternateSelectPin
);
  initial
  begin
    serClk             = 1'b0;
    serData            = 1'b0;
    latchEn            = 1'b1;
    alternateSelectPin = 1'b0;
  end

  // MSB first inside one latch-low window; 125 ns bit period
  task automatic send_frame(input logic [15:0] word, input int nBits);
    int i;
    begin
      latchEn = 1'b0;
      #62.5;
      for (i = 0; i < nBits; i++)
      begin
        serData = word[15-i];
        #62.5;
        serClk = 1'b1;
        #62.5;
        serClk = 1'b0;
      end
      #62.5;
      latchEn = 1'b1;
      // Stale data must not look like a held bit
      serData = ~serData;
      // Return at once so the caller still sees the one-cycle acknowledge
    end
  endtask

  task automatic set_select(input logic level);
    alternateSelectPin = level;
  endtask
endmodule // ssa_host_model

/* File: tb/ssa_control_bench.sv */
// Purpose: Self-checking bench of the serial step attenuator control
// Assumes: Chip-ID pins at 101 unless a scenario opens them
// Notes:   Expected codes come from the frame layout and package constants
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) \
  begin \
    nCompared++; \
    if ((got) !== (exp)) \
    begin \
      errCount++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module ssa_control_bench;
  localparam logic [2:0] MY_ID = 3'h5;
  logic       core_clk;
  logic       sys_rst;
  logic       serClk;
  logic       serData;
  logic       latchEn;
  logic       alternateSelectPin;
  logic [2:0] chipPins;
  logic [2:0] chipIdOpen;
  logic [6:0] coreCellEn_r;
  logic       altActive_r;
  logic       frameAck_r;
  int         errCount;
  int         nCompared;

  ssa_host_model host_u (.serClk(serClk), .serData(serData), .latchEn(latchEn),
    .alternateSelectPin(alternateSelectPin));
  ssa_control dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .serClk(serClk),
    .serData(serData), .latchEn(latchEn), .alternateSelectPin(alternateSelectPin),
    .chipIdPin0(chipPins[0]), .chipIdPin1(chipPins[1]), .chipIdPin2(chipPins[2]),
    .chipIdOpen(chipIdOpen), .coreCellEn_r(coreCellEn_r), .altActive_r(altActive_r),
    .frameAck_r(frameAck_r));

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [15:0] word(input logic [2:0] c, input logic [3:0] r,
                                       input logic [7:0] d);
    return {c, 1'b0, r, d};
  endfunction

  // Frame, then count ack cycles and look at the core drive
  task automatic wr(input logic [15:0] w, input int n, input logic [3:0] ackExp,
                    input logic [6:0] coreExp);
    logic [3:0] acks;
    begin
      acks = 4'h0;
      host_u.send_frame(w, n);
      step(1);
      repeat (12)
      begin
        if (frameAck_r === 1'b1)
          acks++;
        step(1);
      end
      `CHECK_EQ(acks, ackExp)
      `CHECK_EQ(coreCellEn_r, coreExp)
    end
  endtask

  task automatic sel(input logic lvl, input logic [6:0] coreExp, input logic altExp);
    host_u.set_select(lvl);
    step(8);
    `CHECK_EQ(coreCellEn_r, coreExp)
    `CHECK_EQ(altActive_r, altExp)
  endtask

  task automatic do_reset;
    sys_rst = 1'b1;
    step(16);
    sys_rst = 1'b0;
    step(4);
    `CHECK_EQ(coreCellEn_r, ssa_pkg::PRIMARY_RST)
    `CHECK_EQ(altActive_r, 1'b0)
  endtask

  task automatic t_primary;
    logic [6:0] codes [9];
    int i;
    begin
      codes = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h7f};
      // Alternating spare bit 7 must not reach the core
      for (i = 0; i < 9; i++)
        wr(word(MY_ID, ssa_pkg::REG_PRIMARY, {i[0], codes[i]}),
           16, 4'h1, codes[i]);
    end
  endtask

  task automatic t_refuse;
    wr(word(MY_ID, ssa_pkg::REG_PRIMARY, 8'h22), 16, 4'h1, 7'h22);
    wr(word(MY_ID ^ 3'h1, ssa_pkg::REG_PRIMARY, 8'h11), 16, 4'h0, 7'h22);
    wr(word(MY_ID, ssa_pkg::REG_PRIMARY, 8'h11), 15, 4'h0, 7'h22);
    wr(word(MY_ID, 4'h3, 8'h11), 16, 4'h1, 7'h22);
  endtask

  task automatic t_select;
    sel(1'b1, 7'h22, 1'b0);
    wr(word(MY_ID, ssa_pkg::REG_CONFIG, 8'h02), 16, 4'h1, 7'h22);
    wr(word(MY_ID, ssa_pkg::REG_CONFIG, 8'h03), 16, 4'h1, ssa_pkg::ALTERNATE_RST);
    `CHECK_EQ(altActive_r, 1'b1)
    wr(word(MY_ID, ssa_pkg::REG_ALTERNATE, 8'h85), 16, 4'h1, 7'h05);
    sel(1'b0, 7'h22, 1'b0);
    sel(1'b1, 7'h05, 1'b1);
    wr(word(MY_ID, ssa_pkg::REG_CONFIG, 8'h01), 16, 4'h1, 7'h22);
  endtask

  task automatic t_default_id;
    // Driven levels oppose the pull pattern; open flags must win
    chipPins   = 3'h1;
    chipIdOpen = 3'h7;
    step(4);
    wr(word(ssa_pkg::CHIP_ID_DEFAULT, ssa_pkg::REG_PRIMARY, 8'h33), 16, 4'h1, 7'h33);
    wr(word(3'h1, ssa_pkg::REG_PRIMARY, 8'h44), 16, 4'h0, 7'h33);
    chipPins   = MY_ID;
    chipIdOpen = 3'h0;
    step(4);
  endtask

  task automatic t_reset_again;
    wr(word(MY_ID, ssa_pkg::REG_CONFIG, 8'h03), 16, 4'h1, 7'h05);
    do_reset();
    // Select still high, feature must be off after reset
    wr(word(MY_ID, ssa_pkg::REG_PRIMARY, 8'h10), 16, 4'h1, 7'h10);
    wr(word(MY_ID, ssa_pkg::REG_CONFIG, 8'h03), 16, 4'h1, ssa_pkg::ALTERNATE_RST);
  endtask

  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    // About 22 frames of 2.2 us each plus resets; leave over twice that
    #120000;
    errCount++;
    give_verdict();
  end

  initial
  begin
    errCount   = 0;
    nCompared  = 0;
    chipPins   = MY_ID;
    chipIdOpen = 3'h0;
    step(0);
    do_reset();
    t_primary();
    t_refuse();
    t_select();
    t_default_id();
    t_reset_again();
    give_verdict();
  end
endmodule // ssa_control_bench
